// file: shared/csf_regs.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          clock source failover unit.
// Assumes: Byte addresses on an 8-bit register address port.
// Notes:   Definitions only.
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CSF_OFF_CTRL 8'h00
`define CSF_OFF_STATUS 8'h04
`define CSF_OFF_IRQ_STAT 8'h08
`define CSF_OFF_IRQ_EN 8'h0C
`define CSF_OFF_IRQ_CLR 8'h10
`define CSF_OFF_PRESC 8'h14

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define CSF_CTRL_EXT_SEL 0
`define CSF_CTRL_PLL_MON 1
`define CSF_STAT_SRC_EXT 0
`define CSF_STAT_PLL_LOCK 1
`define CSF_IRQ_EXT_FAIL 0
`define CSF_IRQ_PLL_FAIL 1
`define CSF_IRQ_PLL_LOCK 2
`define CSF_IRQ_W 3
`define CSF_PRESC_AHB_LSB 0
`define CSF_PRESC_FAST_LSB 8
`define CSF_PRESC_SLOW_LSB 16
`define CSF_AHB_DIV_W 4
`define CSF_APB_DIV_W 3

// ----------------------------------------------------------------------
// Reset values, frequencies and counts
// ----------------------------------------------------------------------
`define CSF_CTRL_RST 2'h0
`define CSF_PRESC_RST 32'h0000_0000
`define CSF_IRQ_EN_RST 3'h0
`define CSF_RC_FREQ_MHZ 8
`define CSF_EXT_MIN_MHZ 4
`define CSF_EXT_MAX_MHZ 32
`define CSF_SYS_FREQ_MHZ 100
`define CSF_FAIL_WIN_RC 4

`endif

// file: shared/csf_pkg.sv
// Purpose: Types shared by the clock source failover unit.
// Assumes: Nothing beyond the register header.
// Notes:   Types only; numbers live in csf_regs.svh.
package csf_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        CSF_SRC_RC,
        CSF_SRC_EXT
    } csf_src_t;

endpackage

// file: design/csf_prescaler.sv
// Purpose: Divides a stream of one-cycle ticks by a programmable value.
// Assumes: tick_in is a one-cycle pulse on clk_sys.
// Notes:   Output tick fires on every (div+1)-th input tick.
`timescale 1ns/1ps
`default_nettype none

module csf_prescaler import csf_pkg::*; #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tick_in,
    input wire logic [W-1:0] div,
    output logic tick_out
);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    if (W < 1 || W > 8) begin : g_bad_w
        $error("csf_prescaler: W must be 1 to 8");
    end

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    logic [W-1:0] cnt_r;

    // A divider change takes effect on the next input tick, even mid-period;
    // the count wraps at once if it already reaches the new value.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (cnt_r >= div) begin
                    cnt_r <= '0;
                    tick_out <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: design/csf_top.sv
// Purpose: System clock source selection, failure monitoring, fallback
//          and bus clock prescaling.
// Assumes: Oscillator inputs are asynchronous to clk_sys and slower than
//          half its rate; they are sampled, not used as clocks.
// Notes:   Bus clocks leave as one-cycle tick enables on clk_sys.
`timescale 1ns/1ps
`default_nettype none

`include "csf_regs.svh"

// Contract
// R1 - After any reset the internal 8 MHz RC oscillator is the system source.
// R2 - Software may select the external 4-32 MHz clock; it is then monitored.
// R3 - On external clock failure the source falls back to RC automatically.
// R4 - External failure raises an interrupt only when its enable is set.
// R5 - PLL input path events raise maskable interrupts, including oscillator loss.
// R6 - System, fast and slow peripheral bus clocks have separate prescalers.
// R7 - Software keeps system and fast bus under 72 MHz, slow under 36.
// R8 - Failure is no clock edge within a fixed RC window; flag latches.
module csf_top import csf_pkg::*; #(
    parameter int AW = 8,
    parameter int DW = 32,
    parameter int FAIL_WIN = `CSF_FAIL_WIN_RC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DW-1:0] rd_data,
    input wire logic rc_osc_clk,
    input wire logic ext_hs_clk,
    input wire logic pll_ref_clk,
    input wire logic pll_locked,
    output logic sys_src_ext,
    output logic ahb_tick,
    output logic fast_tick,
    output logic slow_tick,
    output logic irq
);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    if (FAIL_WIN < 2 || FAIL_WIN > 255) begin : g_bad_win
        $error("csf_top: FAIL_WIN must be 2 to 255");
    end
    if (AW < 5 || DW < 32) begin : g_bad_bus
        $error("csf_top: AW must be at least 5 and DW at least 32");
    end

    localparam int CW = $clog2(FAIL_WIN + 1);
    localparam logic [CW-1:0] WIN_LAST = CW'(FAIL_WIN - 1);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_s;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_s <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Oscillator and lock sampling
    // ------------------------------------------------------------------
    // Bit order: 0 RC, 1 external, 2 PLL reference, 3 PLL lock.
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_d_r;

    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_d_r <= 4'h0;
        end else begin
            pin_s1_r <= {pll_locked, pll_ref_clk, ext_hs_clk, rc_osc_clk};
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    logic rc_rise;
    logic ext_rise;
    logic lock_rise;
    logic [1:0] mon_edge;

    assign rc_rise = pin_s2_r[0] & ~pin_d_r[0];
    assign ext_rise = pin_s2_r[1] & ~pin_d_r[1];
    assign lock_rise = pin_s2_r[3] & ~pin_d_r[3];
    // Either edge counts as life, so a clock stuck high or low both fail.
    assign mon_edge = pin_s2_r[2:1] ^ pin_d_r[2:1];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic [DW-1:0] presc_r;
    logic [`CSF_IRQ_W-1:0] irq_en_r;
    logic [`CSF_IRQ_W-1:0] irq_stat_r;
    csf_src_t src_r;

    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [7:0] off);
        hit = (a == AW'(off));
    endfunction

    logic wr_ctrl;
    logic wr_clr;

    assign wr_ctrl = wr_en && hit(addr, `CSF_OFF_CTRL);
    assign wr_clr = wr_en && hit(addr, `CSF_OFF_IRQ_CLR);

    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            presc_r <= DW'(`CSF_PRESC_RST);
            irq_en_r <= `CSF_IRQ_EN_RST;
        end else if (wr_en) begin
            if (hit(addr, `CSF_OFF_PRESC)) begin
                presc_r <= wr_data; // R6
            end
            if (hit(addr, `CSF_OFF_IRQ_EN)) begin
                irq_en_r <= wr_data[`CSF_IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Failure monitors: 0 external system clock, 1 PLL reference
    // ------------------------------------------------------------------
    logic [1:0] mon_on;
    logic [1:0] fail_evt;
    logic [CW-1:0] mon_cnt [2];

    assign mon_on[0] = (src_r == CSF_SRC_EXT); // R2
    assign mon_on[1] = ctrl_r[`CSF_CTRL_PLL_MON]; // R5

    for (genvar i = 0; i < 2; i++) begin : g_mon
        // Window is counted in RC periods so it scales with the fallback
        // clock, not with clk_sys.
        assign fail_evt[i] = mon_on[i] && rc_rise && !mon_edge[i] &&
                             (mon_cnt[i] == WIN_LAST); // R8

        always_ff @(posedge clk_sys or negedge rst_n_s) begin
            if (!rst_n_s) begin
                mon_cnt[i] <= '0;
            end else if (!mon_on[i] || mon_edge[i] || fail_evt[i]) begin
                mon_cnt[i] <= '0;
            end else if (rc_rise) begin
                mon_cnt[i] <= mon_cnt[i] + 1'b1; // R8
            end
        end
    end

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    // Selecting the external clock is refused while its failure flag is
    // still set, so a dead oscillator cannot be picked again unnoticed.
    logic sel_ok;

    assign sel_ok = wr_ctrl && wr_data[`CSF_CTRL_EXT_SEL] &&
                    !irq_stat_r[`CSF_IRQ_EXT_FAIL];

    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            src_r <= CSF_SRC_RC; // R1
        end else begin
            unique case (src_r)
                CSF_SRC_RC: begin
                    if (sel_ok) begin
                        src_r <= CSF_SRC_EXT; // R2
                    end
                end
                CSF_SRC_EXT: begin
                    if (fail_evt[0]) begin
                        src_r <= CSF_SRC_RC; // R3
                    end else if (wr_ctrl &&
                                 !wr_data[`CSF_CTRL_EXT_SEL]) begin
                        src_r <= CSF_SRC_RC;
                    end
                end
            endcase
        end
    end

    // The select bit follows the hardware fallback so software reads the
    // source actually in use.
    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl_r <= `CSF_CTRL_RST; // R1
        end else begin
            if (wr_ctrl) begin
                ctrl_r[`CSF_CTRL_PLL_MON] <= wr_data[`CSF_CTRL_PLL_MON];
                ctrl_r[`CSF_CTRL_EXT_SEL] <= sel_ok;
            end
            if (fail_evt[0]) begin
                ctrl_r[`CSF_CTRL_EXT_SEL] <= 1'b0; // R3
            end
        end
    end

    assign sys_src_ext = (src_r == CSF_SRC_EXT);

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [`CSF_IRQ_W-1:0] evt;

    assign evt = {lock_rise, fail_evt[1], fail_evt[0]};

    // A new event in the cycle of its clear keeps the bit set.
    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r &
                           ~(wr_clr ? wr_data[`CSF_IRQ_W-1:0] : '0)) |
                          evt; // R8 R5
        end
    end

    assign irq = |(irq_stat_r & irq_en_r); // R4 R5

    // ------------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------------
    logic src_tick;

    assign src_tick = (src_r == CSF_SRC_EXT) ? ext_rise : rc_rise;

    // Fast and slow bus dividers are fed from the system bus tick.
    csf_prescaler #(.W(`CSF_AHB_DIV_W)) u_ahb (
        .clk_sys(clk_sys),
        .rst_n(rst_n_s),
        .tick_in(src_tick),
        .div(presc_r[`CSF_PRESC_AHB_LSB +: `CSF_AHB_DIV_W]),
        .tick_out(ahb_tick)
    ); // R6

    csf_prescaler #(.W(`CSF_APB_DIV_W)) u_fast (
        .clk_sys(clk_sys),
        .rst_n(rst_n_s),
        .tick_in(ahb_tick),
        .div(presc_r[`CSF_PRESC_FAST_LSB +: `CSF_APB_DIV_W]),
        .tick_out(fast_tick)
    ); // R6

    csf_prescaler #(.W(`CSF_APB_DIV_W)) u_slow (
        .clk_sys(clk_sys),
        .rst_n(rst_n_s),
        .tick_in(ahb_tick),
        .div(presc_r[`CSF_PRESC_SLOW_LSB +: `CSF_APB_DIV_W]),
        .tick_out(slow_tick)
    ); // R6

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [DW-1:0] rd_nxt;

    always_comb begin
        rd_nxt = '0;
        if (hit(addr, `CSF_OFF_CTRL)) begin
            rd_nxt[1:0] = ctrl_r;
        end else if (hit(addr, `CSF_OFF_STATUS)) begin
            rd_nxt[`CSF_STAT_SRC_EXT] = (src_r == CSF_SRC_EXT);
            rd_nxt[`CSF_STAT_PLL_LOCK] = pin_s2_r[3];
        end else if (hit(addr, `CSF_OFF_IRQ_STAT)) begin
            rd_nxt[`CSF_IRQ_W-1:0] = irq_stat_r;
        end else if (hit(addr, `CSF_OFF_IRQ_EN)) begin
            rd_nxt[`CSF_IRQ_W-1:0] = irq_en_r;
        end else if (hit(addr, `CSF_OFF_PRESC)) begin
            rd_nxt = presc_r;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_en ? rd_nxt : '0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n_s);

    reset_source_a: assert property ( // R1
        $rose(rst_n_s) |-> !sys_src_ext && !ctrl_r[`CSF_CTRL_EXT_SEL])
        else $error("source not RC after reset");

    ext_select_a: assert property ( // R2
        sel_ok && !sys_src_ext |=> sys_src_ext)
        else $error("external select not taken");

    monitor_run_a: assert property ( // R2
        sys_src_ext && !mon_edge[0] && rc_rise && mon_cnt[0] != WIN_LAST
        |=> mon_cnt[0] == $past(mon_cnt[0]) + 1'b1)
        else $error("monitor not counting on external source");

    fallback_a: assert property ( // R3
        fail_evt[0] |=> !sys_src_ext && !ctrl_r[`CSF_CTRL_EXT_SEL])
        else $error("no fallback after failure");

    fail_irq_a: assert property ( // R4
        fail_evt[0] |=> (irq_stat_r[0] && (irq == irq_en_r[0] ||
                         (irq_stat_r[2:1] & irq_en_r[2:1]) != 0)))
        else $error("failure interrupt wrong");

    pll_irq_a: assert property ( // R5
        fail_evt[1] || lock_rise |=>
        (irq_stat_r[1] || !$past(fail_evt[1])) &&
        (irq_stat_r[2] || !$past(lock_rise)))
        else $error("PLL event not recorded");

    presc_chain_a: assert property ( // R6
        fast_tick || slow_tick |-> $past(ahb_tick))
        else $error("bus tick without system tick");

    fail_window_a: assert property ( // R8
        sys_src_ext && rc_rise && !mon_edge[0] && mon_cnt[0] == WIN_LAST
        |=> !sys_src_ext ##0 irq_stat_r[0][*2])
        else $error("window expiry not flagged");

endmodule

`default_nettype wire

// file: tb/csf_osc_model.sv
// Purpose: Oscillator side of the clock source failover unit.
// Assumes: Free-running internal RC oscillator at 8 MHz; external and
//          PLL reference oscillators can be stopped by the bench.
// Notes:   A stopped oscillator holds its output low, as a dead crystal
//          gives no edges at all.
`timescale 1ns/1ps
`default_nettype none

module csf_osc_model #(
    parameter real EXT_HALF_NS = 125.0,
    parameter real PLL_HALF_NS = 62.5
) (
    input wire logic ext_run,
    input wire logic pll_run,
    output logic rc_osc_clk,
    output logic ext_hs_clk,
    output logic pll_ref_clk
);
    // ------------------------------------------------------------------
    // Oscillators
    // ------------------------------------------------------------------
    // The external clock sits at the slow end of its range, 4 MHz, so the
    // failure window sees the fewest edges it is ever allowed to see.
    initial begin
        rc_osc_clk = 1'b0;
        ext_hs_clk = 1'b0;
        pll_ref_clk = 1'b0;
    end
    always #62.5 rc_osc_clk = ~rc_osc_clk;
    always #(EXT_HALF_NS) ext_hs_clk = ext_run ? ~ext_hs_clk : 1'b0;
    always #(PLL_HALF_NS) pll_ref_clk = pll_run ? ~pll_ref_clk : 1'b0;
endmodule
`default_nettype wire

// file: tb/clock_source_failover_tb.sv
// Purpose: Self-checking bench for the clock source failover unit.
// Assumes: Register port with one-cycle read data; FAIL_WIN of 4.
// Notes:   Oscillators are asynchronous, so waits are bounded polls.
`timescale 1ns/1ps
`default_nettype none
`include "csf_regs.svh"

module clock_source_failover_tb import csf_pkg::*;;
    typedef struct {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] exp;
    } csf_row_t;
    csf_row_t rows[6] = '{
        '{8'h0C, 32'h7, 8'h0C, 32'h7},
        '{8'h0C, 32'h0, 8'h0C, 32'h0},
        '{8'h14, 32'h0007_070F, 8'h14, 32'h0007_070F},
        '{8'h14, 32'h0, 8'h14, 32'h0},
        '{8'h18, 32'hFFFF_FFFF, 8'h18, 32'h0},
        '{8'h10, 32'h7, 8'h10, 32'h0}
    };
    logic clk_sys, rstn, wr_en, rd_en, ext_run, pll_run, pll_locked;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data;
    logic rc_osc_clk, ext_hs_clk, pll_ref_clk, sys_src_ext, irq;
    logic ahb_tick, fast_tick, slow_tick, cnt_en, rc_q;
    int failures, checks_done, n_rc, n_ahb, n_fast, n_slow;

    csf_osc_model u_osc (.ext_run(ext_run), .pll_run(pll_run),
        .rc_osc_clk(rc_osc_clk), .ext_hs_clk(ext_hs_clk),
        .pll_ref_clk(pll_ref_clk));
    csf_top #(.FAIL_WIN(4)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .rc_osc_clk(rc_osc_clk),
        .ext_hs_clk(ext_hs_clk), .pll_ref_clk(pll_ref_clk),
        .pll_locked(pll_locked), .sys_src_ext(sys_src_ext),
        .ahb_tick(ahb_tick), .fast_tick(fast_tick),
        .slow_tick(slow_tick), .irq(irq));

    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        rc_q <= rc_osc_clk;
        if (cnt_en) begin
            n_rc <= n_rc + int'(rc_osc_clk & ~rc_q);
            n_ahb <= n_ahb + int'(ahb_tick);
            n_fast <= n_fast + int'(fast_tick);
            n_slow <= n_slow + int'(slow_tick);
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] e,
                       input string m);
        checks_done++;
        if (seen !== e) begin
            failures++;
            $display("[ERR] %0t %s: got %h want %h", $time, m, seen, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string m);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, e, m);
    endtask

    // Polls for either the fallback (sel 0) or the interrupt (sel 1).
    task automatic wait_for(input logic sel);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            #1;
            if (sel ? irq === 1'b1 : sys_src_ext === 1'b0)
                return;
        end
        failures++;
        $display("[ERR] %0t wait timed out", $time);
        stop_test();
    endtask

    task automatic do_reset;
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    function automatic logic [31:0] near(input int a, input int b,
                                         input int tol);
        return {31'h0, (a - b <= tol) && (b - a <= tol)};
    endfunction

    initial begin
        #500us;
        failures++;
        $display("[ERR] %0t run limit reached", $time);
        stop_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ext_run = 1'b1;
        pll_run = 1'b1;
        pll_locked = 1'b0;
        cnt_en = 1'b0;
        do_reset();
        chk(sys_src_ext, 32'h0, "source after reset");
        rdchk(`CSF_OFF_CTRL, 32'h0, "ctrl reset");
        rdchk(`CSF_OFF_PRESC, 32'h0, "presc reset");
        rdchk(`CSF_OFF_IRQ_STAT, 32'h0, "flags reset");
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rdchk(rows[i].ra, rows[i].exp, "register row");
        end
        $display("test registers done");

        // Failover with the interrupt enabled, then a refused reselect.
        wr(`CSF_OFF_IRQ_EN, 32'h1);
        wr(`CSF_OFF_CTRL, 32'h1);
        chk(sys_src_ext, 32'h1, "external selected");
        repeat (200) @(posedge clk_sys);
        #1;
        chk(sys_src_ext, 32'h1, "no false failure");
        rdchk(`CSF_OFF_STATUS, 32'h1, "status ext");
        @(posedge clk_sys);
        #1;
        chk(rd_data, 32'h0, "read data one cycle only");
        ext_run = 1'b0;
        wait_for(1'b0);
        chk(irq, 32'h1, "irq on failure");
        rdchk(`CSF_OFF_IRQ_STAT, 32'h1, "fail flag");
        rdchk(`CSF_OFF_CTRL, 32'h0, "ctrl back to rc");
        wr(`CSF_OFF_CTRL, 32'h1);
        rdchk(`CSF_OFF_CTRL, 32'h0, "reselect refused");
        wr(`CSF_OFF_IRQ_CLR, 32'h1);
        chk(irq, 32'h0, "irq cleared");
        $display("test failover done");

        // Failover with the interrupt masked.
        ext_run = 1'b1;
        wr(`CSF_OFF_IRQ_EN, 32'h0);
        repeat (50) @(posedge clk_sys);
        wr(`CSF_OFF_CTRL, 32'h1);
        ext_run = 1'b0;
        wait_for(1'b0);
        repeat (5) @(posedge clk_sys);
        #1;
        chk(irq, 32'h0, "masked failure");
        rdchk(`CSF_OFF_IRQ_STAT, 32'h1, "flag still set");
        wr(`CSF_OFF_IRQ_EN, 32'h1);
        chk(irq, 32'h1, "unmasked flag");
        wr(`CSF_OFF_IRQ_CLR, 32'h1);
        $display("test masked done");

        // PLL reference loss, then lock gained.
        pll_run = 1'b0;
        wr(`CSF_OFF_IRQ_EN, 32'h2);
        wr(`CSF_OFF_CTRL, 32'h2);
        wait_for(1'b1);
        rdchk(`CSF_OFF_IRQ_STAT, 32'h2, "pll ref flag");
        chk(sys_src_ext, 32'h0, "source kept");
        wr(`CSF_OFF_CTRL, 32'h0);
        pll_run = 1'b1;
        wr(`CSF_OFF_IRQ_CLR, 32'h7);
        rdchk(`CSF_OFF_IRQ_STAT, 32'h0, "pll flag cleared");
        wr(`CSF_OFF_IRQ_EN, 32'h4);
        @(posedge clk_sys);
        pll_locked <= 1'b1;
        wait_for(1'b1);
        rdchk(`CSF_OFF_IRQ_STAT, 32'h4, "lock flag");
        rdchk(`CSF_OFF_STATUS, 32'h2, "lock status");
        wr(`CSF_OFF_IRQ_CLR, 32'h4);
        chk(irq, 32'h0, "lock irq cleared");
        $display("test pll done");

        // Reset while running from the external clock.
        ext_run = 1'b1;
        repeat (50) @(posedge clk_sys);
        wr(`CSF_OFF_CTRL, 32'h1);
        chk(sys_src_ext, 32'h1, "ext selected again");
        wr(`CSF_OFF_CTRL, 32'h0);
        chk(sys_src_ext, 32'h0, "software deselect");
        rdchk(`CSF_OFF_CTRL, 32'h0, "ctrl after deselect");
        wr(`CSF_OFF_CTRL, 32'h1);
        chk(sys_src_ext, 32'h1, "ext before reset");
        do_reset();
        chk(sys_src_ext, 32'h0, "rc after reset");
        rdchk(`CSF_OFF_CTRL, 32'h0, "ctrl after reset");
        rdchk(`CSF_OFF_IRQ_EN, 32'h0, "enable after reset");
        $display("test midrun reset done");

        // Prescalers: system /4, fast /2, slow /3, all well under limits.
        wr(`CSF_OFF_PRESC, 32'h0002_0103);
        @(negedge clk_sys);
        n_rc = 0;
        n_ahb = 0;
        n_fast = 0;
        n_slow = 0;
        cnt_en = 1'b1;
        repeat (1600) @(negedge clk_sys);
        cnt_en = 1'b0;
        chk(near(n_ahb * 4, n_rc, 4), 32'h1, "system ratio");
        chk(near(n_fast * 2, n_ahb, 2), 32'h1, "fast ratio");
        chk(near(n_slow * 3, n_ahb, 3), 32'h1, "slow ratio");
        chk(near(n_ahb, 0, 10), 32'h0, "system ticks seen");
        $display("test prescaler done");
        stop_test();
    end
endmodule
`default_nettype wire
